/* File: design/sa_mul_exec.sv */
// execution of shift amount moves, upper product moves and signed multiplies
// assumes the issue stage presents one decoded word per pipe with operands
`timescale 1ns/1ps
`default_nettype none
module sa_mul_exec (
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        p0_valid_i,
  input  wire logic [31:0] p0_instr_i,
  input  wire logic [63:0] p0_rs_val_i,
  input  wire logic [63:0] p0_rt_val_i,
  input  wire logic        p1_valid_i,
  input  wire logic [31:0] p1_instr_i,
  input  wire logic [63:0] p1_rs_val_i,
  input  wire logic [63:0] p1_rt_val_i,
  input  wire logic        rd_lo0_i,
  input  wire logic        rd_hi0_i,
  input  wire logic        rd_lo1_i,
  input  wire logic        rd_hi1_i,
  output logic             p1_illegal_o,
  output logic             stall_o,
  output logic             gpr_we_o,
  output logic [4:0]       gpr_waddr_o,
  output logic [63:0]      gpr_wdata_o,
  output logic [6:0]       shift_amount_o,
  output logic [127:0]     upper_product_o,
  output logic [127:0]     bottom_product_o,
  output logic             arith_exc_o
);
  typedef enum logic [1:0] {
    OP_NONE    = 2'b00,
    OP_PIPE0   = 2'b01,
    OP_PIPE1   = 2'b10
  } mul_owner_e;

  // decode shared by both pipes
  function automatic logic is_special_fn(input logic [31:0] w,
                                         input logic [5:0] fn);
    is_special_fn = (w[31:26] == sa_mul_pkg::OP_SPECIAL) && (w[5:0] == fn);
  endfunction
  function automatic logic is_mmi_fn(input logic [31:0] w,
                                     input logic [5:0] fn);
    is_mmi_fn = (w[31:26] == sa_mul_pkg::OP_MMI) && (w[5:0] == fn);
  endfunction
  function automatic logic is_register_immediate_opcode(input logic [31:0] w,
                                     input logic [4:0] sel);
    is_register_immediate_opcode = (w[31:26] == sa_mul_pkg::OP_REGISTER_IMMEDIATE_OPCODE) && (w[20:16] == sel);
  endfunction

  wire p0_read_sa  = p0_valid_i && is_special_fn(p0_instr_i,
                                                 sa_mul_pkg::FN_READ_SA);
  wire p0_restore  = p0_valid_i && is_special_fn(p0_instr_i,
                                                 sa_mul_pkg::FN_RESTORE);
  wire p0_set_byte = p0_valid_i && is_register_immediate_opcode(p0_instr_i,
                                             sa_mul_pkg::SEL_SET_BYTE);
  wire p0_set_half = p0_valid_i && is_register_immediate_opcode(p0_instr_i,
                                             sa_mul_pkg::SEL_SET_HALF);
  wire p0_signed_product_pipe_zero     = p0_valid_i && is_special_fn(p0_instr_i,
                                                 sa_mul_pkg::FN_SIGNED_PRODUCT_PIPE_ZERO);
  wire p0_wr_up1   = p0_valid_i && is_mmi_fn(p0_instr_i,
                                             sa_mul_pkg::FN_WR_UP1);
  wire p0_wr_bot1  = p0_valid_i && is_mmi_fn(p0_instr_i,
                                             sa_mul_pkg::FN_WR_BOT1);
  wire p1_signed_product_pipe_zero     = p1_valid_i && is_mmi_fn(p1_instr_i,
                                             sa_mul_pkg::FN_SIGNED_PRODUCT_PIPE_ZERO);
  wire p1_sa_op    = p1_valid_i &&
                     (is_special_fn(p1_instr_i, sa_mul_pkg::FN_READ_SA) ||
                      is_special_fn(p1_instr_i, sa_mul_pkg::FN_RESTORE) ||
                      is_register_immediate_opcode(p1_instr_i, sa_mul_pkg::SEL_SET_BYTE) ||
                      is_register_immediate_opcode(p1_instr_i, sa_mul_pkg::SEL_SET_HALF));
  wire p1_wr_up1   = p1_valid_i && is_mmi_fn(p1_instr_i,
                                             sa_mul_pkg::FN_WR_UP1);
  wire p1_wr_bot1  = p1_valid_i && is_mmi_fn(p1_instr_i,
                                             sa_mul_pkg::FN_WR_BOT1);

  // pipe 1 copies of shift amount ops are flagged and never executed
  assign p1_illegal_o = p1_sa_op;

  // byte and halfword counts become bit counts
  wire [3:0] byte_cnt = p0_rs_val_i[3:0] ^ p0_instr_i[3:0];
  wire [2:0] half_cnt = p0_rs_val_i[2:0] ^ p0_instr_i[2:0];
  wire [6:0] sa_byte  = {byte_cnt, 3'h0};
  wire [6:0] sa_half  = {half_cnt, 4'h0};

  // A stage: one register stage after issue
  logic       sa_we_q;
  logic [6:0] sa_wval_q;
  logic [6:0] sa_q;
  wire        sa_we_d   = p0_restore || p0_set_byte || p0_set_half;
  wire [6:0]  sa_wval_d = p0_set_byte ? sa_byte :
                          p0_set_half ? sa_half :
                          p0_rs_val_i[6:0];

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sa_we_q   <= 1'b0;
      sa_wval_q <= sa_mul_pkg::SA_RESET;
    end else begin
      sa_we_q   <= sa_we_d;
      sa_wval_q <= sa_wval_d;
    end
  end

  // commit in A stage; the gap rule means no reader races this write
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sa_q <= sa_mul_pkg::SA_RESET;
    end else if (sa_we_q) begin
      sa_q <= sa_wval_q;
    end
  end
  assign shift_amount_o = sa_q;

  // multiplier: pipe 0 wins if both issue the same cycle, pipe 1 held back
  wire        mul_busy;
  wire        p1_blocked = p1_signed_product_pipe_zero && p0_signed_product_pipe_zero;
  wire        mul_start  = (p0_signed_product_pipe_zero || p1_signed_product_pipe_zero) && !mul_busy;
  wire [63:0] mul_a      = p0_signed_product_pipe_zero ? p0_rs_val_i : p1_rs_val_i;
  wire [63:0] mul_b      = p0_signed_product_pipe_zero ? p0_rt_val_i : p1_rt_val_i;
  wire [4:0]  mul_rd     = p0_signed_product_pipe_zero ? p0_instr_i[15:11] : p1_instr_i[15:11];
  wire        mul_done;
  wire [63:0] mul_prod;

  // only low words used; upper operand bits are not checked
  word_multiplier u_mul (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .start_i    (mul_start),
    .op_a_i     (mul_a[31:0]),
    .op_b_i     (mul_b[31:0]),
    .done_o     (mul_done),
    .prod_o     (mul_prod)
  );

  mul_owner_e owner_q;
  logic [4:0] mul_rd_q;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      owner_q  <= OP_NONE;
      mul_rd_q <= 5'h00;
    end else if (mul_start) begin
      owner_q  <= p0_signed_product_pipe_zero ? OP_PIPE0 : OP_PIPE1;
      mul_rd_q <= mul_rd;
    end else if (mul_done) begin
      owner_q  <= OP_NONE;
    end
  end
  assign mul_busy = (owner_q != OP_NONE) && !mul_done;

  // sign-extended halves of the product
  wire [63:0] lo_ext = {{32{mul_prod[31]}}, mul_prod[31:0]};
  wire [63:0] hi_ext = {{32{mul_prod[63]}}, mul_prod[63:32]};

  logic       done_p0;
  logic       done_p1;
  always_comb begin
    case (owner_q)
      OP_PIPE0: begin
        done_p0 = mul_done;
        done_p1 = 1'b0;
      end
      OP_PIPE1: begin
        done_p0 = 1'b0;
        done_p1 = mul_done;
      end
      default: begin
        done_p0 = 1'b0;
        done_p1 = 1'b0;
      end
    endcase
  end

  logic [127:0] hi_q;
  logic [127:0] lo_q;
  wire          up1_we   = p0_wr_up1 || p1_wr_up1;
  wire          bot1_we  = p0_wr_bot1 || p1_wr_bot1;
  wire [63:0]   up1_val  = p0_wr_up1 ? p0_rs_val_i : p1_rs_val_i;
  wire [63:0]   bot1_val = p0_wr_bot1 ? p0_rs_val_i : p1_rs_val_i;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hi_q <= {2{sa_mul_pkg::PROD_RESET}};
    end else begin
      if (done_p0) begin
        hi_q[63:0] <= hi_ext;
      end
      if (done_p1) begin
        hi_q[127:64] <= hi_ext;
      end else if (up1_we) begin
        hi_q[127:64] <= up1_val;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lo_q <= {2{sa_mul_pkg::PROD_RESET}};
    end else begin
      if (done_p0) begin
        lo_q[63:0] <= lo_ext;
      end
      if (done_p1) begin
        lo_q[127:64] <= lo_ext;
      end else if (bot1_we) begin
        lo_q[127:64] <= bot1_val;
      end
    end
  end
  assign upper_product_o  = hi_q;
  assign bottom_product_o = lo_q;

  // interlock: reads of a pending half, or a second multiply, wait
  wire pend0 = owner_q == OP_PIPE0;
  wire pend1 = owner_q == OP_PIPE1;
  assign stall_o = (pend0 && (rd_lo0_i || rd_hi0_i)) ||
                   (pend1 && (rd_lo1_i || rd_hi1_i)) ||
                   ((p0_signed_product_pipe_zero || p1_signed_product_pipe_zero) && mul_busy) ||
                   p1_blocked;

  // general register write port; read_sa and multiply share it, and
  // when both write in one cycle the multiply result wins and read_sa is dropped
  wire        mul_gpr_we  = mul_done && (mul_rd_q != 5'h00);
  wire        rsa_gpr_we  = p0_read_sa &&
                            (p0_instr_i[15:11] != 5'h00);
  logic       gpr_we_q;
  logic [4:0] gpr_waddr_q;
  logic [63:0] gpr_wdata_q;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gpr_we_q    <= 1'b0;
      gpr_waddr_q <= 5'h00;
      gpr_wdata_q <= sa_mul_pkg::PROD_RESET;
    end else if (mul_gpr_we) begin
      gpr_we_q    <= 1'b1;
      gpr_waddr_q <= mul_rd_q;
      gpr_wdata_q <= lo_ext;
    end else begin
      gpr_we_q    <= rsa_gpr_we;
      gpr_waddr_q <= p0_instr_i[15:11];
      gpr_wdata_q <= {57'h0, sa_q};
    end
  end
  assign gpr_we_o    = gpr_we_q;
  assign gpr_waddr_o = gpr_waddr_q;
  assign gpr_wdata_o = gpr_wdata_q;

  // overflow is left to software
  assign arith_exc_o = 1'b0;
endmodule
`default_nettype wire

/* File: design/sa_mul_pkg.sv */
// constants for the shift amount and word multiply execution block
// assumes a core that decodes 32-bit instruction words on core_clk_i
package sa_mul_pkg;
  localparam logic [5:0] OP_SPECIAL   = 6'h00;
  localparam logic [5:0] OP_REGISTER_IMMEDIATE_OPCODE    = 6'h01;
  localparam logic [5:0] OP_MMI       = 6'h1C;
  localparam logic [5:0] FN_READ_SA   = 6'h28;
  localparam logic [5:0] FN_RESTORE   = 6'h29;
  localparam logic [5:0] FN_WR_UP1    = 6'h11;
  localparam logic [5:0] FN_WR_BOT1   = 6'h13;
  localparam logic [5:0] FN_SIGNED_PRODUCT_PIPE_ZERO      = 6'h18;
  localparam logic [4:0] SEL_SET_BYTE = 5'h18;
  localparam logic [4:0] SEL_SET_HALF = 5'h19;
  localparam int         OPC_MSB      = 31;
  localparam int         OPC_LSB      = 26;
  localparam int         RS_LSB       = 21;
  localparam int         RT_LSB       = 16;
  localparam int         RD_LSB       = 11;
  localparam int         BYTE_SHIFT   = 3;
  localparam int         HALF_SHIFT   = 4;
  localparam int         MUL_LAT      = 3;
  localparam logic [63:0] PROD_RESET  = 64'h0;
  localparam logic [6:0]  SA_RESET    = 7'h00;
endpackage

/* File: design/word_multiplier.sv */
// pipelined 32x32 signed multiplier with fixed latency
// assumes caller holds its own bookkeeping of which half is targeted
`timescale 1ns/1ps
`default_nettype none
module word_multiplier (
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        start_i,
  input  wire logic [31:0] op_a_i,
  input  wire logic [31:0] op_b_i,
  output logic             done_o,
  output logic [63:0]      prod_o
);
  logic [sa_mul_pkg::MUL_LAT-1:0] vld_q;
  logic [63:0]                    stage_q [sa_mul_pkg::MUL_LAT];
  wire  [63:0] prod_full = 64'($signed(op_a_i) * $signed(op_b_i));

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      vld_q <= '0;
    end else begin
      vld_q <= {vld_q[sa_mul_pkg::MUL_LAT-2:0], start_i};
    end
  end

  genvar g;
  generate
    for (g = 0; g < sa_mul_pkg::MUL_LAT; g++) begin : g_stage
      always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          stage_q[g] <= sa_mul_pkg::PROD_RESET;
        end else if (g == 0) begin
          stage_q[g] <= prod_full;
        end else begin
          stage_q[g] <= stage_q[(g == 0) ? 0 : g-1];
        end
      end
    end
  endgenerate

  assign done_o = vld_q[sa_mul_pkg::MUL_LAT-1];
  assign prod_o = stage_q[sa_mul_pkg::MUL_LAT-1];
endmodule
`default_nettype wire

/* File: bench/sa_mul_exec_monitor.sv */
// assertions on the ports of the shift amount and multiply block
// assumes one clock domain and an async active-low reset
`timescale 1ns/1ps
`default_nettype none
module sa_mul_exec_monitor (
  input wire logic         core_clk_i,
  input wire logic         reset_n_i,
  input wire logic         p0_valid_i,
  input wire logic [31:0]  p0_instr_i,
  input wire logic [63:0]  p0_rs_val_i,
  input wire logic [63:0]  p0_rt_val_i,
  input wire logic         p1_valid_i,
  input wire logic [31:0]  p1_instr_i,
  input wire logic [63:0]  p1_rs_val_i,
  input wire logic [63:0]  p1_rt_val_i,
  input wire logic         rd_hi1_i,
  input wire logic         p1_illegal_o,
  input wire logic         stall_o,
  input wire logic         gpr_we_o,
  input wire logic [4:0]   gpr_waddr_o,
  input wire logic [63:0]  gpr_wdata_o,
  input wire logic [6:0]   shift_amount_o,
  input wire logic [127:0] upper_product_o,
  input wire logic [127:0] bottom_product_o,
  input wire logic         arith_exc_o
);
  wire [5:0] op0  = p0_instr_i[31:26];
  wire [5:0] fn0  = p0_instr_i[5:0];
  wire [4:0] rd0  = p0_instr_i[15:11];
  wire       go0  = p0_valid_i && !stall_o;
  wire       imm0 = go0 && op0 == sa_mul_pkg::OP_REGISTER_IMMEDIATE_OPCODE;
  wire       sb0  = imm0 && p0_instr_i[20:16] == sa_mul_pkg::SEL_SET_BYTE;
  wire       sh0  = imm0 && p0_instr_i[20:16] == sa_mul_pkg::SEL_SET_HALF;
  wire       sp0  = go0 && op0 == sa_mul_pkg::OP_SPECIAL;
  wire       rsa0 = sp0 && fn0 == sa_mul_pkg::FN_READ_SA;
  wire       mul0 = sp0 && fn0 == sa_mul_pkg::FN_SIGNED_PRODUCT_PIPE_ZERO;
  wire       mul1 = p1_valid_i && !stall_o
                 && p1_instr_i[31:26] == sa_mul_pkg::OP_MMI
                 && p1_instr_i[5:0] == sa_mul_pkg::FN_SIGNED_PRODUCT_PIPE_ZERO;
  wire       bad1 = p1_valid_i && p1_instr_i[31:26] == sa_mul_pkg::OP_REGISTER_IMMEDIATE_OPCODE
                 && p1_instr_i[20:16] == sa_mul_pkg::SEL_SET_BYTE;
  // full products kept one cycle so results can be compared later
  logic signed [63:0] pr0_q;
  logic signed [63:0] pr1_q;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pr0_q <= '0;
      pr1_q <= '0;
    end else begin
      pr0_q <= $signed(p0_rs_val_i[31:0]) * $signed(p0_rt_val_i[31:0]);
      pr1_q <= $signed(p1_rs_val_i[31:0]) * $signed(p1_rt_val_i[31:0]);
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_mul1;
    mul1;
  endsequence
  sequence s_mul0_rd;
    mul0 && rd0 != 5'h00;
  endsequence
  chk_no_arith_exc: assert property (!arith_exc_o)
    else $error("arithmetic exception raised");
  chk_p1_set_refused: assert property (bad1 |-> p1_illegal_o)
    else $error("shift set on pipe 1 not refused");
  chk_byte_count: assert property (sb0 |-> ##2 shift_amount_o ==
    {$past(p0_rs_val_i[3:0], 2) ^ $past(p0_instr_i[3:0], 2), 3'h0})
    else $error("byte shift amount wrong");
  chk_half_count: assert property (sh0 |-> ##2 shift_amount_o ==
    {$past(p0_rs_val_i[2:0], 2) ^ $past(p0_instr_i[2:0], 2), 4'h0})
    else $error("halfword shift amount wrong");
  chk_sa_to_gpr: assert property (rsa0 |=> gpr_we_o &&
    gpr_waddr_o == $past(rd0) &&
    gpr_wdata_o == {57'h0, $past(shift_amount_o)})
    else $error("shift amount copy wrong");
  // halves are written on the edge after done, so seen four edges on
  chk_mul0_words: assert property (mul0 |-> ##4
    bottom_product_o[63:0] == 64'($signed($past(pr0_q[31:0], 3))) &&
    upper_product_o[63:0] == 64'($signed($past(pr0_q[63:32], 3))))
    else $error("pipe 0 product halves wrong");
  chk_mul0_gpr: assert property (s_mul0_rd |-> ##4 gpr_we_o &&
    gpr_waddr_o == $past(rd0, 4))
    else $error("multiply register write missing");
  chk_mul_rd_zero: assert property (mul0 && rd0 == 5'h00 |->
    ##4 !gpr_we_o)
    else $error("multiply to register zero wrote");
  chk_mul1_upper: assert property (s_mul1 |-> ##4
    bottom_product_o[127:64] == 64'($signed($past(pr1_q[31:0], 3))) &&
    upper_product_o[127:64] == 64'($signed($past(pr1_q[63:32], 3))))
    else $error("pipe 1 product halves wrong");
  chk_stall_pending: assert property (s_mul1 ##1 rd_hi1_i |-> stall_o)
    else $error("early product read not stalled");
endmodule
bind sa_mul_exec sa_mul_exec_monitor mon (.*);
`default_nettype wire

/* File: bench/issue_model.sv */
// issue pipeline model: presents one word per pipe, holds it on stall
// assumes issue is called just after a rising edge of core_clk_i
`timescale 1ns/1ps
`default_nettype none
module issue_model (
  input  wire logic        core_clk_i,
  input  wire logic        stall_i,
  output logic [1:0]       valid_o,
  output logic [1:0][31:0] instr_o,
  output logic [1:0][63:0] rs_o,
  output logic [1:0][63:0] rt_o
);
  initial begin
    valid_o = '0;
    instr_o = '0;
    rs_o = '0;
    rt_o = '0;
  end
  task automatic issue(input int p, input logic [31:0] ins,
                       input logic [63:0] a, input logic [63:0] b,
                       output bit ok);
    int n;
    n = 0;
    valid_o[p] = 1'b1;
    instr_o[p] = ins;
    rs_o[p] = a;
    rt_o[p] = b;
    #1;
    while (stall_i && n < 8) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    @(posedge core_clk_i);
    #1;
    valid_o[p] = 1'b0;
    // released lines carry junk so a stale word is never mistaken
    instr_o[p] = ~ins;
    rs_o[p] = ~a;
    rt_o[p] = ~b;
    ok = n < 8;
  endtask
endmodule
`default_nettype wire

/* File: bench/shift_amount_and_word_multiply_bench.sv */
// self-checking bench for the shift amount and word multiply block
// assumes the checker binds itself to the design
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fails++; \
  $display("[FAIL] %0t got %h want %h", $time, a, e); end end
module shift_amount_and_word_multiply_bench;
  logic             core_clk_i;
  logic             reset_n_i;
  logic             rd_lo0_i, rd_hi0_i, rd_lo1_i, rd_hi1_i;
  logic [1:0]       valid;
  logic [1:0][31:0] instr;
  logic [1:0][63:0] rs_v;
  logic [1:0][63:0] rt_v;
  logic             p1_illegal_o, stall_o, gpr_we_o, arith_exc_o;
  logic [4:0]       gpr_waddr_o;
  logic [63:0]      gpr_wdata_o;
  logic [6:0]       shift_amount_o;
  logic [127:0]     upper_product_o, bottom_product_o;
  int               fails, cmp_count;
  bit               ok;
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  sa_mul_exec dut (.*, .p0_valid_i(valid[0]), .p0_instr_i(instr[0]),
    .p0_rs_val_i(rs_v[0]), .p0_rt_val_i(rt_v[0]), .p1_valid_i(valid[1]),
    .p1_instr_i(instr[1]), .p1_rs_val_i(rs_v[1]), .p1_rt_val_i(rt_v[1]));
  issue_model mdl (.core_clk_i, .stall_i(stall_o), .valid_o(valid),
    .instr_o(instr), .rs_o(rs_v), .rt_o(rt_v));
  task automatic summarize();
    $display("mismatches %0d of %0d compares", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic go(input int p, input logic [31:0] w,
                    input logic [63:0] a, input logic [63:0] b);
    mdl.issue(p, w, a, b, ok);
    if (!ok) begin
      fails++;
      summarize();
    end
  endtask
  // no shift reads precede these sets
  task automatic t_sets();
    logic [63:0] rs [4];
    logic [15:0] imm [4];
    logic [6:0]  ex [4];
    logic [6:0]  old;
    rs = '{64'h5, 64'hF0F, 64'h7, 64'hFF};
    imm = '{16'h3, 16'h0, 16'h2, 16'hFFF8};
    ex = '{7'h30, 7'h78, 7'h50, 7'h70};
    for (int i = 0; i < 4; i++) begin
      old = shift_amount_o;
      go(0, {sa_mul_pkg::OP_REGISTER_IMMEDIATE_OPCODE, 5'h01, i < 2 ? sa_mul_pkg::SEL_SET_BYTE
             : sa_mul_pkg::SEL_SET_HALF, imm[i]}, rs[i], '0);
      `CHK(shift_amount_o, old)
      tick(1);
      `CHK(shift_amount_o, ex[i])
      tick(1);
    end
  endtask
  task automatic t_save_restore();
    go(0, {sa_mul_pkg::OP_SPECIAL, 10'h000, 5'h07, 5'h00,
           sa_mul_pkg::FN_READ_SA}, '0, '0);
    `CHK({gpr_we_o, gpr_waddr_o}, 6'h27)
    `CHK(gpr_wdata_o, 64'h70)
    tick(1);
    tick(3); // quiet slots before the restore
    go(0, {sa_mul_pkg::OP_SPECIAL, 5'h02, 15'h0000, sa_mul_pkg::FN_RESTORE},
       64'h28, '0);
    tick(2);
    `CHK(shift_amount_o, 7'h28)
    fork
      go(1, {sa_mul_pkg::OP_REGISTER_IMMEDIATE_OPCODE, 5'h01, sa_mul_pkg::SEL_SET_BYTE,
             16'h0001}, '0, '0);
      begin #1; `CHK(p1_illegal_o, 1'b1) end
    join
    tick(1);
    go(1, {sa_mul_pkg::OP_SPECIAL, 10'h000, 5'h07, 5'h00,
           sa_mul_pkg::FN_READ_SA}, '0, '0);
    `CHK(gpr_we_o, 1'b0)
    `CHK(shift_amount_o, 7'h28)
    tick(1);
  endtask
  task automatic t_mult0();
    go(0, {sa_mul_pkg::OP_SPECIAL, 5'h01, 5'h02, 5'h05, 5'h00,
           sa_mul_pkg::FN_SIGNED_PRODUCT_PIPE_ZERO}, 64'h2, 64'hFFFFFFFFFFFFFFFD);
    rd_lo0_i = 1'b1;
    #1;
    `CHK(stall_o, 1'b1)
    rd_lo0_i = 1'b0;
    tick(3);
    `CHK(bottom_product_o[63:0], 64'hFFFFFFFFFFFFFFFA)
    `CHK(upper_product_o[63:0], 64'hFFFFFFFFFFFFFFFF)
    `CHK({gpr_we_o, gpr_waddr_o}, 6'h25)
    `CHK(gpr_wdata_o, 64'hFFFFFFFFFFFFFFFA)
    tick(1);
    go(0, {sa_mul_pkg::OP_SPECIAL, 5'h01, 5'h02, 5'h00, 5'h00,
           sa_mul_pkg::FN_SIGNED_PRODUCT_PIPE_ZERO}, 64'h7FFFFFFF, 64'h7FFFFFFF);
    tick(3);
    `CHK(upper_product_o[63:0], 64'h3FFFFFFF)
    `CHK(bottom_product_o[63:0], 64'h1)
    `CHK(gpr_we_o, 1'b0)
    tick(1);
    `CHK(arith_exc_o, 1'b0)
  endtask
  task automatic t_signed_product_pipe_one();
    int n;
    go(1, {sa_mul_pkg::OP_MMI, 5'h01, 5'h02, 5'h06, 5'h00,
           sa_mul_pkg::FN_SIGNED_PRODUCT_PIPE_ZERO}, 64'hFFFFFFFF80000000, 64'h2);
    rd_hi1_i = 1'b1;
    #1;
    `CHK(stall_o, 1'b1)
    n = 0;
    while (stall_o === 1'b1 && n < 8) begin
      tick(1);
      n++;
    end
    if (n == 8) begin
      fails++;
      summarize();
    end
    rd_hi1_i = 1'b0;
    `CHK({gpr_we_o, gpr_waddr_o}, 6'h26)
    `CHK(gpr_wdata_o, 64'h0)
    `CHK(upper_product_o[127:64], 64'hFFFFFFFFFFFFFFFF)
    `CHK(bottom_product_o[127:64], 64'h0)
    `CHK(bottom_product_o[63:0], 64'h1)
    tick(2);
  endtask
  task automatic t_wr1();
    go(0, {sa_mul_pkg::OP_MMI, 5'h03, 15'h0000, sa_mul_pkg::FN_WR_UP1},
       64'h0123456789ABCDEF, '0);
    tick(1);
    `CHK(upper_product_o[127:64], 64'h0123456789ABCDEF)
    go(0, {sa_mul_pkg::OP_MMI, 5'h03, 15'h0000, sa_mul_pkg::FN_WR_BOT1},
       64'hFEDCBA9876543210, '0);
    tick(1);
    `CHK(bottom_product_o[127:64], 64'hFEDCBA9876543210)
    `CHK(upper_product_o[63:0], 64'h3FFFFFFF)
  endtask
  initial begin
    reset_n_i = 1'b0;
    {rd_lo0_i, rd_hi0_i, rd_lo1_i, rd_hi1_i} = 4'h0;
    repeat (5) @(posedge core_clk_i);
    #1;
    reset_n_i = 1'b1;
    `CHK(shift_amount_o, 7'h00)
    t_sets();
    t_save_restore();
    t_mult0();
    t_signed_product_pipe_one();
    t_wr1();
    summarize();
  end
endmodule
`default_nettype wire
